// ### logic/rcrc_pkg.sv
/*
  shared constants and carriers for the radio control sequencer.
  assumes a single 10 MHz clock domain and synchronous inputs.
*/
package rcrc_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int GPO_SEL_W = 6;
  localparam logic [5:0] GPO_SEL_CCA = 6'h09;
  localparam logic [5:0] GPO_SEL_CLK = 6'h3f;
  localparam int GPO_DIV = 192;
  localparam int OSC_SETTLE_NS = 2000;
  localparam int OSC_SETTLE_CYC =
    (OSC_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [1:0] CCA_ALWAYS = 2'h0;
  localparam logic [1:0] CCA_RSSI = 2'h1;
  localparam logic [1:0] CCA_NOPKT = 2'h2;
  localparam logic [1:0] CCA_BOTH = 2'h3;
  localparam logic [4:0] ST_SLEEP = 5'h00;
  localparam logic [4:0] ST_IDLE = 5'h01;
  localparam logic [4:0] ST_OSC_OFF = 5'h02;
  localparam logic [4:0] ST_RX = 5'h0d;
  localparam logic [4:0] ST_FSTX = 5'h12;
  localparam logic [4:0] ST_TX = 5'h13;

  typedef struct packed {
    logic resetStrobe;
    logic idleStrobe;
    logic receiveStrobe;
    logic transmitStrobe;
    logic synthOnStrobe;
    logic oscOffStrobe;
    logic powerDownStrobe;
  } rcrc_strobe_s;

  typedef struct packed {
    logic [1:0] clearChannelModeSelect;
    logic oscKeepOn;
    logic [5:0] outputSelectField;
  } rcrc_cfg_s;
endpackage

// ### logic/rcrc_clk_div.sv
/*
  divides the clock by an even ratio to a square wave.
  assumes ratio is even and at least four.
*/
`timescale 1ns/1ps
module rcrc_clk_div #(
  parameter int RATIO = 192
) (
  input wire logic clk,
  input wire logic srst,
  output logic divClk
);
  localparam int CW = $clog2(RATIO / 2);
  localparam logic [CW-1:0] HALF_M1 = CW'(RATIO / 2 - 1);
  logic [CW-1:0] count;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      count <= '0;
      divClk <= 1'b0;
    end
    else if (count == HALF_M1)
    begin
      count <= '0;
      divClk <= ~divClk;
    end
    else
    begin
      count <= count + CW'(1);
    end
  end
endmodule

// ### logic/radio_control_reset_cca.sv
/*
  radio control sequencer: reset, oscillator control, tx-if-cca gating.
  assumes decoded one-cycle strobes and synchronous level inputs.
*/
// Functional notes
// - general output shows clear-channel when its select is 0x09.
// - tx or synth strobe in receive moves only if channel is clear.
// - a refused request is never retried; host must strobe again.
// - mode picks always, rssi below, not receiving, or both.
// - state changes by strobes or internal events like tx underflow.
// - current state number is readable as status.
// - after reset first general output is clock divided by 192.
// - chip ready low shown on serial out when chip select low.
// - after power-on reset: idle with oscillator running.
// - serial out high until oscillator stable, then low.
// - reset strobe restores defaults and enters idle.
// - keep-on bit holds oscillator on, else automatic control.
// - osc-off and power-down strobes act only from idle.
// - oscillator stops on chip select high, restarts on low, idle.
// - forced-on oscillator keeps running in sleep.
// - idle strobe forces idle from any state.
// - receive strobe during transmit ends it and enters receive.
`timescale 1ns/1ps
module radio_control_reset_cca #(
  parameter int SETTLE_CYC = rcrc_pkg::OSC_SETTLE_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire rcrc_pkg::rcrc_strobe_s strobe,
  input wire rcrc_pkg::rcrc_cfg_s cfg,
  input wire logic chipSelectLow,
  input wire logic rssiBelowThreshold,
  input wire logic receivingPacket,
  input wire logic txUnderflow,
  input wire logic txDone,
  output logic generalOutputZero,
  output logic serialOut,
  output logic chipReadyLow,
  output logic oscRunning,
  output logic clearChannel,
  output logic [4:0] radioStateStatus
);
  import rcrc_pkg::*;

  typedef enum logic [5:0] {
    S_SLEEP = 6'h01,
    S_IDLE = 6'h02,
    S_OSC_OFF = 6'h04,
    S_RX = 6'h08,
    S_FSTX = 6'h10,
    S_TX = 6'h20
  } rcrc_state_e;

  localparam int SW = $clog2(SETTLE_CYC + 1);
  localparam logic [SW-1:0] SETTLE_MAX = SW'(SETTLE_CYC);

  rcrc_state_e state, next_state;
  logic [SW-1:0] settle;
  logic oscStable, oscWanted, chipSelectLowPrev, divClk, next_cca;
  logic softReset, strobeOk;

  assign softReset = srst | strobe.resetStrobe;
  assign oscStable = oscRunning && (settle == SETTLE_MAX);
  // gate on the ready pin itself, one cycle after the settle count
  assign strobeOk = oscStable && !chipReadyLow;

  // mode select of the clear-channel condition
  always_comb
  begin
    unique case (cfg.clearChannelModeSelect)
      CCA_ALWAYS: next_cca = 1'b1;
      CCA_RSSI: next_cca = rssiBelowThreshold;
      CCA_NOPKT: next_cca = ~receivingPacket;
      CCA_BOTH: next_cca = rssiBelowThreshold & ~receivingPacket;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (softReset)
      clearChannel <= 1'b0;
    else
      clearChannel <= next_cca;
  end

  // a sleeping or off oscillator only stops once chip select is released
  always_comb
  begin
    oscWanted = 1'b1;
    if (!cfg.oscKeepOn && !chipSelectLow)
      oscWanted = !(state == S_SLEEP || state == S_OSC_OFF);
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      oscRunning <= 1'b1;
      settle <= '0;
    end
    else if (!oscWanted)
    begin
      oscRunning <= 1'b0;
      settle <= '0;
    end
    else
    begin
      oscRunning <= 1'b1;
      if (strobe.resetStrobe)
        settle <= '0;
      else if (settle != SETTLE_MAX)
        settle <= settle + SW'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      chipSelectLowPrev <= 1'b0;
    else
      chipSelectLowPrev <= chipSelectLow;
  end

  always_comb
  begin
    next_state = state;
    if (strobe.idleStrobe)
      next_state = S_IDLE;
    else if ((state == S_SLEEP || state == S_OSC_OFF) && chipSelectLow
             && !chipSelectLowPrev)
      next_state = S_IDLE;
    else if (strobeOk)
    begin
      unique case (state)
        S_IDLE:
        begin
          if (strobe.oscOffStrobe)
            next_state = S_OSC_OFF;
          else if (strobe.powerDownStrobe)
            next_state = S_SLEEP;
          else if (strobe.receiveStrobe)
            next_state = S_RX;
          else if (strobe.transmitStrobe)
            next_state = S_TX;
          else if (strobe.synthOnStrobe)
            next_state = S_FSTX;
        end
        S_RX:
        begin
          // refusal leaves no pending request behind
          if (strobe.transmitStrobe && clearChannel)
            next_state = S_TX;
          else if (strobe.synthOnStrobe && clearChannel)
            next_state = S_FSTX;
        end
        S_FSTX:
        begin
          if (strobe.transmitStrobe)
            next_state = S_TX;
          else if (strobe.receiveStrobe)
            next_state = S_RX;
        end
        S_TX:
        begin
          if (strobe.receiveStrobe)
            next_state = S_RX;
          else if (txUnderflow || txDone)
            next_state = S_IDLE;
        end
        S_SLEEP, S_OSC_OFF: next_state = state;
        default: next_state = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (softReset)
      state <= S_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge clk)
  begin
    if (softReset)
      radioStateStatus <= ST_IDLE;
    else
    begin
      unique case (next_state)
        S_SLEEP: radioStateStatus <= ST_SLEEP;
        S_IDLE: radioStateStatus <= ST_IDLE;
        S_OSC_OFF: radioStateStatus <= ST_OSC_OFF;
        S_RX: radioStateStatus <= ST_RX;
        S_FSTX: radioStateStatus <= ST_FSTX;
        S_TX: radioStateStatus <= ST_TX;
        default: radioStateStatus <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (softReset)
    begin
      chipReadyLow <= 1'b1;
      serialOut <= 1'b0;
    end
    else
    begin
      chipReadyLow <= ~oscStable;
      serialOut <= chipSelectLow ? ~oscStable : 1'b0;
    end
  end

  rcrc_clk_div #(
    .RATIO(GPO_DIV)
  ) rcrc_clk_div_i (
    .clk(clk),
    .srst(softReset),
    .divClk(divClk)
  );

  // select 0x3f is the reset default; the host should move off it
  always_ff @(posedge clk)
  begin
    if (softReset)
      generalOutputZero <= 1'b0;
    else if (cfg.outputSelectField == GPO_SEL_CCA)
      generalOutputZero <= next_cca;
    else if (cfg.outputSelectField == GPO_SEL_CLK)
      generalOutputZero <= divClk;
    else
      generalOutputZero <= 1'b0;
  end

  a_refuse_stays: assert property (@(posedge clk) disable iff (softReset)
    state == S_RX && !clearChannel && strobe.transmitStrobe
    && !strobe.idleStrobe |=> state == S_RX)
    else $error("refused tx left receive");
  a_no_auto_tx: assert property (@(posedge clk) disable iff (softReset)
    state == S_RX && !strobe.transmitStrobe && !strobe.synthOnStrobe
    |=> state != S_TX && state != S_FSTX)
    else $error("tx entered without strobe");
  a_idle_force: assert property (@(posedge clk) disable iff (srst)
    strobe.idleStrobe |=> state == S_IDLE)
    else $error("idle strobe ignored");
  a_rx_abort: assert property (@(posedge clk) disable iff (softReset)
    state == S_TX && strobeOk && strobe.receiveStrobe
    && !strobe.idleStrobe |=> state == S_RX)
    else $error("receive strobe did not end tx");
  a_reset_idle: assert property (@(posedge clk)
    strobe.resetStrobe && !srst |=> state == S_IDLE && chipReadyLow)
    else $error("reset strobe not to idle");
  a_off_from_idle: assert property (@(posedge clk) disable iff (softReset)
    state != S_IDLE && state != S_OSC_OFF && !srst |=> state != S_OSC_OFF
    || $past(state) == S_IDLE)
    else $error("osc off left other state");
  a_keep_on: assert property (@(posedge clk) disable iff (srst)
    cfg.oscKeepOn |=> oscRunning)
    else $error("forced oscillator stopped");
  a_ready_pin: assert property (@(posedge clk) disable iff (softReset)
    chipSelectLow && oscStable ##1 chipSelectLow && oscStable
    |-> serialOut == 1'b0)
    else $error("serial out not low when ready");
  a_early_ignore: assert property (@(posedge clk) disable iff (softReset)
    !strobeOk && state == S_IDLE && !strobe.idleStrobe
    && !(chipSelectLow && !chipSelectLowPrev) |=> state == S_IDLE)
    else $error("strobe taken before ready");
  a_cca_pin: assert property (@(posedge clk) disable iff (softReset)
    cfg.outputSelectField == GPO_SEL_CCA ##1
    cfg.outputSelectField == GPO_SEL_CCA
    |-> generalOutputZero == clearChannel)
    else $error("cca not on output pin");
endmodule

// ### tb/rcrc_host_model.sv
/*
  host model: drives chip select and one-cycle command strobes.
  assumes the bench requests on rising edges.
*/
`timescale 1ns/1ps
module rcrc_host_model (
  input wire logic clk,
  input wire rcrc_pkg::rcrc_strobe_s reqStrobe,
  input wire logic reqValid,
  input wire logic noWait,
  input wire logic selectReq,
  input wire logic serialOut,
  output rcrc_pkg::rcrc_strobe_s strobe,
  output logic chipSelectLow,
  output logic busy
);
  import rcrc_pkg::*;
  rcrc_strobe_s pending = '0;
  logic held = 1'b0;
  logic ready;
  // port unused until serial out is seen low while selected, unless noWait is set
  assign ready = noWait || (chipSelectLow && !serialOut);
  assign busy = held || (strobe != '0);
  initial strobe = '0;
  initial chipSelectLow = 1'b0;
  always @(posedge clk)
  begin
    chipSelectLow <= selectReq;
    strobe <= '0;
    if (reqValid)
    begin
      pending <= reqStrobe;
      held <= 1'b1;
    end
    else if (held && ready)
    begin
      // later resets need only the reset strobe
      strobe <= pending;
      held <= 1'b0;
    end
  end
endmodule

// ### tb/radio_control_reset_cca_test.sv
/*
  self-checking bench for the radio control sequencer.
  assumes the host model sits on the command side.
*/
`timescale 1ns/1ps
module radio_control_reset_cca_test;
  import rcrc_pkg::*;
  localparam int SET = 8;
  localparam int CS_HIGH_CYC = 400; // 40 us at 100 ns per cycle
  localparam logic [6:0] RST = 7'h40, IDL = 7'h20, RXS = 7'h10;
  localparam logic [6:0] TXS = 7'h08, SYN = 7'h04, OFF = 7'h02;
  localparam logic [6:0] PWD = 7'h01;
  logic clk = 1'b0;
  logic srst = 1'b1;
  rcrc_strobe_s strobe, reqStrobe = '0;
  rcrc_cfg_s cfg = '{CCA_ALWAYS, 1'b0, GPO_SEL_CLK};
  logic reqValid = 1'b0, noWait = 1'b0, selectReq = 1'b1;
  logic rssiBelowThreshold = 1'b0, receivingPacket = 1'b0;
  logic txUnderflow = 1'b0, txDone = 1'b0, chipSelectLow, busy;
  logic generalOutputZero, serialOut, chipReadyLow, oscRunning;
  logic clearChannel;
  logic [4:0] radioStateStatus;
  int failCount = 0, checkCount = 0, cyc = 0;
  always #50 clk = ~clk;
  radio_control_reset_cca #(.SETTLE_CYC(SET)) radio_control_reset_cca_i (
    .clk(clk), .srst(srst), .strobe(strobe), .cfg(cfg),
    .chipSelectLow(chipSelectLow),
    .rssiBelowThreshold(rssiBelowThreshold),
    .receivingPacket(receivingPacket), .txUnderflow(txUnderflow),
    .txDone(txDone), .generalOutputZero(generalOutputZero),
    .serialOut(serialOut), .chipReadyLow(chipReadyLow),
    .oscRunning(oscRunning), .clearChannel(clearChannel),
    .radioStateStatus(radioStateStatus));
  rcrc_host_model rcrc_host_model_i (
    .clk(clk), .reqStrobe(reqStrobe), .reqValid(reqValid),
    .noWait(noWait), .selectReq(selectReq), .serialOut(serialOut),
    .strobe(strobe), .chipSelectLow(chipSelectLow), .busy(busy));
  task automatic endSim();
    $display("checks %0d mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard, well above the fewer than two thousand cycles the run needs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failCount++;
      endSim();
    end
  end
  task automatic check(input string nm, input logic [7:0] seen,
    input logic [7:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      failCount++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // a stuck handshake is caught by the hang guard
  task automatic send(input logic [6:0] s, input logic nw);
    @(posedge clk);
    reqStrobe <= rcrc_strobe_s'(s);
    noWait <= nw;
    reqValid <= 1'b1;
    @(posedge clk);
    reqValid <= 1'b0;
    do @(negedge clk); while (busy !== 1'b0);
    @(negedge clk);
  endtask
  task automatic waitRdy();
    while (chipReadyLow !== 1'b0) @(negedge clk);
  endtask
  task automatic tReset();
    int hi;
    hi = 0;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    // first edge with reset low launches the not-ready level
    repeat (2) @(negedge clk);
    check("state", 8'(radioStateStatus), 8'(ST_IDLE));
    check("osc", 8'(oscRunning), 8'h1);
    check("so", 8'(serialOut), 8'h1);
    check("rdy", 8'(chipReadyLow), 8'h1);
    // early receive strobe must be dropped
    send(RXS, 1'b1);
    check("early", 8'(radioStateStatus), 8'(ST_IDLE));
    waitRdy();
    check("so", 8'(serialOut), 8'h0);
    repeat (384) @(negedge clk) hi += int'(generalOutputZero === 1'b1);
    check("divclk", 8'(hi), 8'hc0);
  endtask
  task automatic tCca();
    logic [1:0] m;
    logic r, p, e, y;
    logic [4:0] g;
    @(posedge clk);
    cfg.outputSelectField <= GPO_SEL_CCA;
    for (int i = 0; i < 16; i++)
    begin
      m = i[3:2];
      r = i[1];
      p = i[0];
      y = i[0] ^ i[2];
      e = m == 0 || (m == 1 && r) || (m == 2 && !p) || (m == 3 && r && !p);
      g = e ? (y ? ST_FSTX : ST_TX) : ST_RX;
      @(posedge clk);
      cfg.clearChannelModeSelect <= m;
      rssiBelowThreshold <= r;
      receivingPacket <= p;
      send(RXS, 1'b0);
      check("cca", 8'(clearChannel), 8'(e));
      check("gpo", 8'(generalOutputZero), 8'(e));
      send(y ? SYN : TXS, 1'b0);
      check("gate", 8'(radioStateStatus), 8'(g));
      @(posedge clk);
      rssiBelowThreshold <= 1'b1;
      receivingPacket <= 1'b0;
      repeat (4) @(negedge clk);
      if (!e)
        check("retry", 8'(radioStateStatus), 8'(ST_RX));
      send(IDL, 1'b0);
      check("idle", 8'(radioStateStatus), 8'(ST_IDLE));
    end
  endtask
  task automatic pulseEnd(input logic u);
    send(TXS, 1'b0);
    @(posedge clk);
    txUnderflow <= u;
    txDone <= !u;
    @(posedge clk);
    txUnderflow <= 1'b0;
    txDone <= 1'b0;
    repeat (2) @(negedge clk);
    check("txend", 8'(radioStateStatus), 8'(ST_IDLE));
  endtask
  task automatic tTx();
    @(posedge clk);
    cfg.clearChannelModeSelect <= CCA_ALWAYS;
    send(TXS, 1'b0);
    send(RXS, 1'b0);
    check("txrx", 8'(radioStateStatus), 8'(ST_RX));
    send(IDL, 1'b0);
    pulseEnd(1'b1);
    pulseEnd(1'b0);
  endtask
  task automatic tOsc();
    logic [6:0] s;
    logic [4:0] lo;
    for (int k = 0; k < 4; k++)
    begin
      s = k[0] ? OFF : PWD;
      lo = k[0] ? ST_OSC_OFF : ST_SLEEP;
      @(posedge clk);
      cfg.oscKeepOn <= k[1];
      send(RXS, 1'b0);
      send(s, 1'b0);
      check("notidle", 8'(radioStateStatus), 8'(ST_RX));
      send(IDL, 1'b0);
      send(s, 1'b0);
      check("low", 8'(radioStateStatus), 8'(lo));
      @(posedge clk);
      selectReq <= 1'b0;
      repeat (3) @(negedge clk);
      check("oscoff", 8'(oscRunning), 8'(k[1]));
      @(posedge clk);
      selectReq <= 1'b1;
      // host model adds one edge before the select reaches the block
      repeat (3) @(negedge clk);
      check("wake", 8'(radioStateStatus), 8'(ST_IDLE));
      check("oscon", 8'(oscRunning), 8'h1);
      waitRdy();
      check("so", 8'(serialOut), 8'h0);
    end
  endtask
  task automatic tRst();
    send(RXS, 1'b0);
    send(RST, 1'b0);
    check("rst", 8'(radioStateStatus), 8'(ST_IDLE));
    check("rstrdy", 8'(chipReadyLow), 8'h1);
    waitRdy();
    check("rstdone", 8'(chipReadyLow), 8'h0);
  endtask
  // manual power-up; chip select is the only host pin modelled here
  task automatic tManual();
    @(posedge clk);
    selectReq <= 1'b0;
    @(posedge clk);
    selectReq <= 1'b1;
    repeat (CS_HIGH_CYC) @(posedge clk);
    selectReq <= 1'b0;
    repeat (2) @(posedge clk);
    selectReq <= 1'b1;
    send(RST, 1'b0);
    check("mstate", 8'(radioStateStatus), 8'(ST_IDLE));
    check("mso", 8'(serialOut), 8'h1);
    waitRdy();
    check("mdone", 8'(serialOut), 8'h0);
  endtask
  initial
  begin
    tReset();
    tCca();
    tTx();
    tOsc();
    tRst();
    tManual();
    endSim();
  end
endmodule
